// >>> logic/tdp_pkg.sv
// Constants and types shared by the timer divider and PWM block
package tdp_pkg;
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic FLOP_RST = 1'b0;
	localparam logic [1:0] TAP_W = 2'h2;
	typedef enum logic [1:0] {
		TDP_MODE_IDLE = 2'b00,
		TDP_MODE_DIV = 2'b01,
		TDP_MODE_PWM = 2'b10
	} tdp_mode_e;
endpackage

// >>> logic/tdp_tick_gen.sv
// Source clock enable pulse generator with selectable divider tap
module tdp_tick_gen
	import tdp_pkg::*;
#(
	parameter int DIV_W = 12
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic [1:0] tapSel,
	// Tick out
	output logic tick
);
	logic [DIV_W-1:0] divCnt_q, divCnt_d;
	logic tick_q, tick_d;
	logic [DIV_W-1:0] tapMask;

	// Tap 0 every cycle, else power-of-four divisions
	always_comb begin
		tapMask = '0;
		case (tapSel)
			2'h0: tapMask = '0;
			2'h1: tapMask = DIV_W'(4'hF) >> 2;
			2'h2: tapMask = DIV_W'(8'h3F) >> 2;
			default: tapMask = DIV_W'(12'hFFF) >> 2;
		endcase
		divCnt_d = divCnt_q + DIV_W'(1);
		tick_d = ((divCnt_q & tapMask) == tapMask);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divCnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// >>> logic/timer_divider_pwm.sv
// Eight-bit timer with divider output and PWM output modes
// Functional notes
// - Divider mode: count ticks, on period match toggle flop, clear, raise irq
// - Divider mode yields a square wave with equal high and low times
// - Divider pin is always the inverse of the output flop
// - Software may load the flop any value; reset clears it to zero
// - Period register is unbuffered; a write takes effect at once
// - Stopping holds the pin; flop value rewritten only after the stop
// - Clearing run stops counting; then writing zero to flop drives pins high
// - PWM mode: toggle flop on duty match, keep counting
// - PWM overflow toggles flop again, clears counter, raises irq
// - PWM pin is inverse of flop; preset selects pulse polarity
// - Running PWM duty write buffered, moved to active at next irq
// - Stopped counter: duty write moves to active register at once
// - Duty read during PWM returns active register contents
// - PWM stop holds pin; flop value changed only after stop
// - Run bit one starts counting, zero halts it
module timer_divider_pwm
	import tdp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control bits
	input wire logic runControlBit,
	input wire logic pwmModeSel,
	input wire logic [1:0] dividerTapSelect,
	input wire logic flopInitWe,
	input wire logic flopInitVal,
	// Data registers
	input wire logic periodWe,
	input wire logic [tdp_pkg::CNT_W-1:0] periodWdata,
	input wire logic dutyWe,
	input wire logic [tdp_pkg::CNT_W-1:0] dutyWdata,
	// Status and readback
	output logic [tdp_pkg::CNT_W-1:0] periodCompareReg,
	output logic [tdp_pkg::CNT_W-1:0] dutyReadData,
	output logic [tdp_pkg::CNT_W-1:0] countValue,
	output logic timerMatchIrq,
	// Pins
	output logic dividerOutPin,
	output logic pulseModOutPin
);
	import tdp_pkg::*;

	logic tick;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] period_q, period_d;
	logic [CNT_W-1:0] dutyBuf_q, dutyBuf_d;
	logic [CNT_W-1:0] dutyAct_q, dutyAct_d;
	logic flop_q, flop_d;
	logic irq_q, irq_d;
	logic divPin_q, divPin_d;
	logic pwmPin_q, pwmPin_d;
	tdp_mode_e mode;
	logic tmrEvt;

	tdp_tick_gen #(
		.DIV_W(12)
	) u_tick (
		.sys_clk(sys_clk),
		.rst(rst),
		.tapSel(dividerTapSelect),
		.tick(tick)
	);

	always_comb begin
		if (!runControlBit)
			mode = TDP_MODE_IDLE;
		else if (pwmModeSel)
			mode = TDP_MODE_PWM;
		else
			mode = TDP_MODE_DIV;
	end

	always_comb begin
		cnt_d = cnt_q;
		flop_d = flop_q;
		period_d = period_q;
		dutyBuf_d = dutyBuf_q;
		dutyAct_d = dutyAct_q;
		irq_d = 1'b0;
		tmrEvt = 1'b0;
		if (periodWe)
			period_d = periodWdata;
		if (dutyWe)
			dutyBuf_d = dutyWdata;
		case (mode)
			TDP_MODE_DIV: begin
				if (tick) begin
					if (cnt_q + CNT_ONE == period_q) begin
						// Match on the incremented value so the half period is period ticks
						flop_d = ~flop_q;
						cnt_d = CNT_ZERO;
						tmrEvt = 1'b1;
					end else begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
			end
			TDP_MODE_PWM: begin
				if (tick) begin
					cnt_d = cnt_q + CNT_ONE;
					if (cnt_q == CNT_MAX) begin
						flop_d = ~flop_q;
						tmrEvt = 1'b1;
					end else if (cnt_q + CNT_ONE == dutyAct_q) begin
						flop_d = ~flop_q;
					end
				end
			end
			default: begin
				// Stopped: counter clears, pins hold unless the flop is loaded
				cnt_d = CNT_ZERO;
				if (flopInitWe)
					flop_d = flopInitVal;
				if (dutyWe)
					dutyAct_d = dutyWdata;
			end
		endcase
		if (tmrEvt) begin
			irq_d = 1'b1;
			// Transfer uses the buffer as already stored; a same-cycle write lands next time
			dutyAct_d = dutyBuf_q;
		end
		divPin_d = ~flop_d;
		pwmPin_d = ~flop_d;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= CNT_ZERO;
			flop_q <= FLOP_RST;
			period_q <= REG_RST;
			dutyBuf_q <= REG_RST;
			dutyAct_q <= REG_RST;
			irq_q <= 1'b0;
			divPin_q <= ~FLOP_RST;
			pwmPin_q <= ~FLOP_RST;
		end else begin
			cnt_q <= cnt_d;
			flop_q <= flop_d;
			period_q <= period_d;
			dutyBuf_q <= dutyBuf_d;
			dutyAct_q <= dutyAct_d;
			irq_q <= irq_d;
			divPin_q <= divPin_d;
			pwmPin_q <= pwmPin_d;
		end
	end

	assign countValue = cnt_q;
	assign periodCompareReg = period_q;
	assign dutyReadData = dutyAct_q;
	assign timerMatchIrq = irq_q;
	assign dividerOutPin = divPin_q;
	assign pulseModOutPin = pwmPin_q;

	// Assertions
	property p_pin_inverse;
		@(posedge sys_clk) disable iff (rst) dividerOutPin == ~flop_q;
	endproperty
	a_pin_inverse: assert property (p_pin_inverse) else $error("div pin not inverse");

	property p_pwm_inverse;
		@(posedge sys_clk) disable iff (rst) pulseModOutPin == ~flop_q;
	endproperty
	a_pwm_inverse: assert property (p_pwm_inverse) else $error("pwm pin not inverse");

	property p_div_match;
		@(posedge sys_clk) disable iff (rst)
		(mode == TDP_MODE_DIV && tick && cnt_q + CNT_ONE == period_q)
		|=> (timerMatchIrq && cnt_q == CNT_ZERO && flop_q != $past(flop_q));
	endproperty
	a_div_match: assert property (p_div_match) else $error("div match missed");

	property p_pwm_ovf;
		@(posedge sys_clk) disable iff (rst)
		(mode == TDP_MODE_PWM && tick && cnt_q == CNT_MAX)
		|=> (timerMatchIrq && cnt_q == CNT_ZERO && dutyAct_q == $past(dutyBuf_q));
	endproperty
	a_pwm_ovf: assert property (p_pwm_ovf) else $error("pwm overflow wrong");

	property p_pwm_duty;
		@(posedge sys_clk) disable iff (rst)
		(mode == TDP_MODE_PWM && tick && cnt_q != CNT_MAX && cnt_q + CNT_ONE == dutyAct_q)
		|=> (flop_q != $past(flop_q) && !timerMatchIrq);
	endproperty
	a_pwm_duty: assert property (p_pwm_duty) else $error("pwm duty toggle missed");

	property p_stop_hold;
		@(posedge sys_clk) disable iff (rst)
		(!runControlBit && !flopInitWe) |=> $stable(dividerOutPin);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("pin moved while stopped");

	property p_stop_duty;
		@(posedge sys_clk) disable iff (rst)
		(!runControlBit && dutyWe) |=> dutyReadData == $past(dutyWdata);
	endproperty
	a_stop_duty: assert property (p_stop_duty) else $error("stopped duty not loaded");

	property p_run_hold;
		@(posedge sys_clk) disable iff (rst)
		(runControlBit && !tmrEvt) |=> dutyAct_q == $past(dutyAct_q);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("duty changed mid period");

	property p_idle_count;
		@(posedge sys_clk) disable iff (rst) !runControlBit |=> countValue == CNT_ZERO;
	endproperty
	a_idle_count: assert property (p_idle_count) else $error("count while stopped");

	c_div_event: cover property (@(posedge sys_clk) mode == TDP_MODE_DIV && tmrEvt);
	c_pwm_event: cover property (@(posedge sys_clk) mode == TDP_MODE_PWM && tmrEvt);
	c_flop_load: cover property (@(posedge sys_clk) !runControlBit && flopInitWe);
endmodule

// >>> tb/tdp_pin_load.sv
// Model of the external load on one output pin
module tdp_pin_load (
	// From the timer pin
	input wire logic outPin,
	// Level seen at the pad
	output logic padLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// Port latch left high so the timer owns the pad
	logic portLatch = 1'b1;
	assign padLevel = outPin & portLatch;
endmodule

// >>> tb/test_timer_divider_pwm.sv
// Self-checking bench for the timer divider and PWM block
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_timer_divider_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	import tdp_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, runControlBit = 1'b0, pwmModeSel = 1'b0;
	logic [1:0] dividerTapSelect = 2'h0;
	logic flopInitWe = 1'b0, flopInitVal = 1'b0, periodWe = 1'b0, dutyWe = 1'b0;
	logic [7:0] periodWdata = 8'h00, dutyWdata = 8'h00;
	logic [7:0] periodCompareReg, dutyReadData, countValue;
	logic timerMatchIrq, dividerOutPin, pulseModOutPin, pad;
	int fails = 0, compares = 0, n;
	always #20 sys_clk = ~sys_clk;
	timer_divider_pwm DUT (.sys_clk(sys_clk), .rst(rst), .runControlBit(runControlBit),
		.pwmModeSel(pwmModeSel), .dividerTapSelect(dividerTapSelect),
		.flopInitWe(flopInitWe), .flopInitVal(flopInitVal), .periodWe(periodWe),
		.periodWdata(periodWdata), .dutyWe(dutyWe), .dutyWdata(dutyWdata),
		.periodCompareReg(periodCompareReg), .dutyReadData(dutyReadData),
		.countValue(countValue), .timerMatchIrq(timerMatchIrq),
		.dividerOutPin(dividerOutPin), .pulseModOutPin(pulseModOutPin));
	tdp_pin_load LOAD (.outPin(pulseModOutPin), .padLevel(pad));
	task automatic cyc(int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// Cycles until the chosen pin changes, bounded so a stuck pin cannot hang
	task automatic gap(input bit pwm, output int c);
		logic v;
		c = 0;
		v = pwm ? pad : dividerOutPin;
		while ((pwm ? pad : dividerOutPin) === v && c < 6000) begin
			cyc(1);
			c++;
		end
	endtask
	task automatic setFlop(logic v);
		@(posedge sys_clk);
		flopInitWe <= 1'b1;
		flopInitVal <= v;
		@(posedge sys_clk);
		flopInitWe <= 1'b0;
		cyc(1);
		`CHK("divPin", ~v, dividerOutPin)
		`CHK("pwmPin", ~v, pulseModOutPin)
	endtask
	// Stop, then see the pin hold before any flop write
	task automatic stopHold(bit pwm);
		logic v;
		@(posedge sys_clk);
		runControlBit <= 1'b0;
		// Pin read only after the stop is sampled
		cyc(1);
		v = pwm ? pad : dividerOutPin;
		cyc(12);
		`CHK("hold", v, pwm ? pad : dividerOutPin)
		setFlop(1'b0);
	endtask
	task automatic t_div;
		for (int t = 0; t < 4; t++) begin
			@(posedge sys_clk);
			dividerTapSelect <= t[1:0];
			periodWe <= 1'b1;
			periodWdata <= 8'h05;
			@(posedge sys_clk);
			periodWe <= 1'b0;
			runControlBit <= 1'b1;
			#1;
			`CHK("period", 8'h05, periodCompareReg)
			gap(0, n);
			gap(0, n);
			`CHK("halfLo", (t == 3) ? 5120 : 5 << (2 * t), n)
			`CHK("irq", 1'b1, timerMatchIrq)
			`CHK("cnt", 8'h00, countValue)
			gap(0, n);
			`CHK("halfHi", (t == 3) ? 5120 : 5 << (2 * t), n)
			stopHold(0);
		end
		@(posedge sys_clk);
		dividerTapSelect <= 2'h0;
		setFlop(1'b1);
		setFlop(1'b0);
	endtask
	task automatic t_pwm;
		@(posedge sys_clk);
		pwmModeSel <= 1'b1;
		dutyWe <= 1'b1;
		dutyWdata <= 8'h40;
		@(posedge sys_clk);
		dutyWe <= 1'b0;
		runControlBit <= 1'b1;
		#1;
		`CHK("dutyStop", 8'h40, dutyReadData)
		gap(1, n);
		gap(1, n);
		`CHK("low", 192, n)
		`CHK("irqPwm", 1'b1, timerMatchIrq)
		`CHK("cntWrap", 8'h00, countValue)
		// Write lands just after the overflow event
		@(posedge sys_clk);
		dutyWe <= 1'b1;
		dutyWdata <= 8'hC0;
		@(posedge sys_clk);
		dutyWe <= 1'b0;
		cyc(1);
		`CHK("dutyRun", 8'h40, dutyReadData)
		gap(1, n);
		`CHK("cntOld", 8'h40, countValue)
		gap(1, n);
		`CHK("lowOld", 192, n)
		gap(1, n);
		`CHK("highNew", 192, n)
		`CHK("dutyNew", 8'hC0, dutyReadData)
		gap(1, n);
		`CHK("lowNew", 64, n)
		stopHold(1);
	endtask
	// Reset while stopped with the flop preset high
	task automatic t_rst;
		setFlop(1'b1);
		@(posedge sys_clk);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		`CHK("rstFlop", 1'b1, dividerOutPin)
		`CHK("rstDuty", 8'h00, dutyReadData)
	endtask
	task automatic complete_run;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 40000);
		fails++;
		complete_run;
	end
	initial begin
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		`CHK("rstCnt", 8'h00, countValue)
		`CHK("rstPin", 1'b1, dividerOutPin)
		t_div;
		t_pwm;
		t_rst;
		complete_run;
	end
endmodule
